// File: verilog/bbce_regs.svh
// Constants for the branch, bit and control execution unit
// Operation
// - Short branch taken only when flag condition holds
// - Short branch: one byte, two cycles, flags kept
// - Bit test branch: three bytes, five cycles
// - Bit test copies tested bit into carry
// - Clear variant branches on zero, set on one
// - Bit set/clear: two bytes, four cycles
// - Bit number from opcode, byte from operand
// - Control opcodes: one byte, two cycles
// - Stop acts as wait under watchdog option
// - Jump and call: 12-bit target, four cycles
// - Direction bit and four-bit branch magnitude
// - Bit operations reach all 256 data bytes
// - Bit test: address byte, then displacement byte
`ifndef BBCE_REGS_SVH
`define BBCE_REGS_SVH

// ****************************************
// Opcode columns
// ****************************************
`define BBCE_COL_CALL 4'h1
`define BBCE_COL_JUMP 4'h9
`define BBCE_COL_BTEST 4'h3
`define BBCE_COL_BDIR 4'hB
`define BBCE_CND_ZCLR 3'h0
`define BBCE_CND_CCLR 3'h2
`define BBCE_CND_ZSET 3'h4
`define BBCE_CND_CSET 3'h6
`define BBCE_OP_NOP 8'h5D
`define BBCE_OP_RET 8'hCD
`define BBCE_OP_INTERRUPT_EXIT 8'h4D
`define BBCE_OP_WAIT 8'h6D
`define BBCE_OP_STOP 8'hED

// ****************************************
// Cycle counts and sizes
// ****************************************
`define BBCE_CYC_SHORT 3'h2
`define BBCE_CYC_CTRL 3'h2
`define BBCE_CYC_EXT 3'h4
`define BBCE_CYC_BDIR 3'h4
`define BBCE_CYC_BTEST 3'h5
`define BBCE_STACK_DEPTH 6
`define BBCE_SP_FULL 3'h6
`define BBCE_RST_PC 12'h000

`endif

// File: verilog/bbce_pkg.sv
// Types for the branch, bit and control execution unit
package bbce_pkg;
  typedef logic [11:0] bbce_pc_t;
  typedef enum logic [3:0] {
    K_SHORT = 4'h0,
    K_BTEST = 4'h1,
    K_BDIR = 4'h2,
    K_JUMP = 4'h3,
    K_CALL = 4'h4,
    K_NOP = 4'h5,
    K_RET = 4'h6,
    K_INTERRUPT_EXIT = 4'h7,
    K_STOP = 4'h8,
    K_WAIT = 4'h9,
    K_FOREIGN = 4'hA
  } bbce_kind_e;
  typedef enum logic [1:0] {
    ST_RUN = 2'h0,
    ST_WAIT = 2'h1,
    ST_STOP = 2'h2
  } bbce_state_e;
endpackage

// File: verilog/bbce_dec_if.sv
// Carrier between the execution core and the opcode decoder
interface bbce_dec_if;
  import bbce_pkg::*;
  logic [7:0] opcode;
  logic zero;
  logic carry;
  logic wdg_option;
  bbce_kind_e kind;
  logic [2:0] last_cnt;
  logic [2:0] bit_idx;
  logic bit_pol;
  logic cond_ok;
  logic disp_fwd;
  logic [3:0] disp_mag;
  modport dec (input opcode, zero, carry, wdg_option,
               output kind, last_cnt, bit_idx, bit_pol, cond_ok, disp_fwd, disp_mag);
  modport core (output opcode, zero, carry, wdg_option,
                input kind, last_cnt, bit_idx, bit_pol, cond_ok, disp_fwd, disp_mag);
endinterface

// File: verilog/bbce_decode.sv
// Opcode decoder for the branch, bit and control execution unit
`include "bbce_regs.svh"
module bbce_decode (
  // Decode carrier
  bbce_dec_if.dec dif
);
  import bbce_pkg::*;

  // ****************************************
  // Column decode
  // ****************************************
  always_comb begin
    dif.kind = K_FOREIGN;
    dif.last_cnt = `BBCE_CYC_CTRL - 3'h1;
    if (!dif.opcode[0]) begin
      dif.kind = K_SHORT;
      dif.last_cnt = `BBCE_CYC_SHORT - 3'h1;
    end else begin
      unique case (dif.opcode[3:0])
        `BBCE_COL_CALL: begin
          dif.kind = K_CALL;
          dif.last_cnt = `BBCE_CYC_EXT - 3'h1;
        end
        `BBCE_COL_JUMP: begin
          dif.kind = K_JUMP;
          dif.last_cnt = `BBCE_CYC_EXT - 3'h1;
        end
        `BBCE_COL_BTEST: begin
          dif.kind = K_BTEST;
          dif.last_cnt = `BBCE_CYC_BTEST - 3'h1;
        end
        `BBCE_COL_BDIR: begin
          dif.kind = K_BDIR;
          dif.last_cnt = `BBCE_CYC_BDIR - 3'h1;
        end
        default: begin
          // Control opcodes are decoded here; everything else is another unit's business and is stepped over
          unique case (dif.opcode)
            `BBCE_OP_NOP: dif.kind = K_NOP;
            `BBCE_OP_RET: dif.kind = K_RET;
            `BBCE_OP_INTERRUPT_EXIT: dif.kind = K_INTERRUPT_EXIT;
            `BBCE_OP_WAIT: dif.kind = K_WAIT;
            `BBCE_OP_STOP: dif.kind = dif.wdg_option ? K_WAIT : K_STOP;
            default: dif.kind = K_FOREIGN;
          endcase
        end
      endcase
    end
  end

  // ****************************************
  // Fields
  // ****************************************
  // Bit number is stored bit-reversed in the high nibble
  assign dif.bit_idx = {dif.opcode[5], dif.opcode[6], dif.opcode[7]};
  assign dif.bit_pol = dif.opcode[4];
  assign dif.disp_fwd = !dif.opcode[3];
  assign dif.disp_mag = dif.opcode[7:4];

  always_comb begin
    unique case (dif.opcode[2:0])
      `BBCE_CND_ZCLR: dif.cond_ok = !dif.zero;
      `BBCE_CND_CCLR: dif.cond_ok = !dif.carry;
      `BBCE_CND_ZSET: dif.cond_ok = dif.zero;
      `BBCE_CND_CSET: dif.cond_ok = dif.carry;
      default: dif.cond_ok = 1'b0;
    endcase
  end
endmodule

// File: verilog/bbce_core.sv
// Execution core for branches, bit operations, control, jump and call
`include "bbce_regs.svh"
module bbce_core (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Program memory
  output bbce_pkg::bbce_pc_t prog_addr,
  input wire logic [7:0] prog_data,
  // Data space
  output logic [7:0] data_addr,
  input wire logic [7:0] data_rdata,
  output logic [7:0] data_wdata,
  output logic data_we,
  // Options and events
  input wire logic wdg_option,
  input wire logic wake,
  input wire logic rti_zero,
  input wire logic rti_carry,
  // Status
  output logic zero_flag,
  output logic carry_flag,
  output logic wait_mode,
  output logic stop_mode,
  output logic instr_done,
  output logic foreign_op
);
  import bbce_pkg::*;

  // ****************************************
  // State
  // ****************************************
  bbce_state_e state;
  logic [2:0] cnt;
  logic [7:0] opcode;
  logic [7:0] operand;
  logic [7:0] disp;
  logic tested;
  logic tested_live;
  bbce_pc_t pc;
  bbce_pc_t next_pc;
  bbce_pc_t stack [`BBCE_STACK_DEPTH];
  logic [2:0] sp;
  logic run;
  logic last;
  logic [7:0] next_wdata;

  bbce_dec_if dif ();

  // Opcode is read straight from memory in the first cycle, held after
  assign dif.opcode = (cnt == 3'h0) ? prog_data : opcode;
  assign dif.zero = zero_flag;
  assign dif.carry = carry_flag;
  assign dif.wdg_option = wdg_option;

  bbce_decode u_decode (
    .dif (dif.dec)
  );

  assign run = (state == ST_RUN);
  assign last = run && (cnt == dif.last_cnt);
  assign tested_live = data_rdata[dif.bit_idx];

  // ****************************************
  // Next program counter
  // ****************************************
  always_comb begin
    next_pc = pc + 12'h001;
    unique case (dif.kind)
      K_SHORT: begin
        if (dif.cond_ok) begin
          if (dif.disp_fwd) begin
            next_pc = pc + 12'h001 + {8'h00, dif.disp_mag};
          end else begin
            next_pc = pc - {8'h00, dif.disp_mag};
          end
        end
      end
      K_BTEST: begin
        if (tested == dif.bit_pol) begin
          next_pc = pc + 12'h002 + {{4{disp[7]}}, disp};
        end else begin
          next_pc = pc + 12'h003;
        end
      end
      K_JUMP, K_CALL: next_pc = {opcode[7:4], operand};
      K_RET, K_INTERRUPT_EXIT: next_pc = stack[sp - 3'h1];
      K_BDIR: next_pc = pc + 12'h002;
      K_NOP, K_STOP, K_WAIT, K_FOREIGN: next_pc = pc + 12'h001;
    endcase
  end

  // ****************************************
  // Sequencing
  // ****************************************
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt <= 3'h0;
    end else if (run) begin
      cnt <= last ? 3'h0 : cnt + 3'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      opcode <= 8'h00;
      operand <= 8'h00;
      disp <= 8'h00;
      tested <= 1'b0;
    end else if (run) begin
      if (cnt == 3'h0) begin
        opcode <= prog_data;
      end
      if (cnt == 3'h1) begin
        operand <= prog_data;
      end
      if (cnt == 3'h2 && dif.kind == K_BTEST) begin
        tested <= tested_live;
        disp <= prog_data;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pc <= `BBCE_RST_PC;
      prog_addr <= `BBCE_RST_PC;
    end else if (last) begin
      pc <= next_pc;
      prog_addr <= next_pc;
    end else if (run && cnt == 3'h0) begin
      prog_addr <= pc + 12'h001;
    end else if (run && cnt == 3'h1 && dif.kind == K_BTEST) begin
      prog_addr <= pc + 12'h002;
    end
  end

  // ****************************************
  // Data space access
  // ****************************************
  always_comb begin
    next_wdata = data_rdata;
    next_wdata[dif.bit_idx] = dif.bit_pol;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      data_addr <= 8'h00;
      data_wdata <= 8'h00;
      data_we <= 1'b0;
    end else begin
      data_we <= 1'b0;
      if (run && cnt == 3'h1) begin
        data_addr <= prog_data;
      end
      if (run && cnt == 3'h2 && dif.kind == K_BDIR) begin
        // Read-modify-write keeps the other seven bits intact
        data_wdata <= next_wdata;
        data_we <= 1'b1;
      end
    end
  end

  // ****************************************
  // Flags
  // ****************************************
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      zero_flag <= 1'b0;
      carry_flag <= 1'b0;
    end else if (last && dif.kind == K_BTEST) begin
      carry_flag <= tested;
    end else if (last && dif.kind == K_INTERRUPT_EXIT) begin
      zero_flag <= rti_zero;
      carry_flag <= rti_carry;
    end
  end

  // ****************************************
  // Return stack
  // ****************************************
  // A push into a full stack overwrites the top entry
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sp <= 3'h0;
      for (int i = 0; i < `BBCE_STACK_DEPTH; i++) begin
        stack[i] <= `BBCE_RST_PC;
      end
    end else if (last && dif.kind == K_CALL) begin
      if (sp == `BBCE_SP_FULL) begin
        stack[sp - 3'h1] <= pc + 12'h002;
      end else begin
        stack[sp] <= pc + 12'h002;
        sp <= sp + 3'h1;
      end
    end else if (last && (dif.kind == K_RET || dif.kind == K_INTERRUPT_EXIT) && sp != 3'h0) begin
      sp <= sp - 3'h1;
    end
  end

  // ****************************************
  // Low power states
  // ****************************************
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state <= ST_RUN;
      wait_mode <= 1'b0;
      stop_mode <= 1'b0;
    end else begin
      unique case (state)
        ST_RUN: begin
          if (last && dif.kind == K_WAIT) begin
            state <= ST_WAIT;
            wait_mode <= 1'b1;
          end else if (last && dif.kind == K_STOP) begin
            state <= ST_STOP;
            stop_mode <= 1'b1;
          end
        end
        ST_WAIT, ST_STOP: begin
          if (wake) begin
            state <= ST_RUN;
            wait_mode <= 1'b0;
            stop_mode <= 1'b0;
          end
        end
        default: begin
          state <= ST_RUN;
          wait_mode <= 1'b0;
          stop_mode <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      instr_done <= 1'b0;
      foreign_op <= 1'b0;
    end else begin
      instr_done <= last;
      foreign_op <= last && dif.kind == K_FOREIGN;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_start_short;
    run && cnt == 3'h0 && dif.kind == K_SHORT;
  endsequence
  sequence s_start_bt;
    run && cnt == 3'h0 && dif.kind == K_BTEST;
  endsequence
  sequence s_start_bd;
    run && cnt == 3'h0 && dif.kind == K_BDIR;
  endsequence
  sequence s_start_call;
    run && cnt == 3'h0 && dif.kind == K_CALL && sp != `BBCE_SP_FULL;
  endsequence
  sequence s_start_jump;
    run && cnt == 3'h0 && dif.kind == K_JUMP;
  endsequence
  sequence s_start_ret;
    run && cnt == 3'h0 && (dif.kind == K_RET || dif.kind == K_INTERRUPT_EXIT) && sp != 3'h0;
  endsequence

  a_short_skip: assert property (s_start_short ##0 !dif.cond_ok |-> ##2 pc == $past(pc, 2) + 12'h001)
    else $error("untaken short branch did not fall through");
  a_short_fwd: assert property (s_start_short ##0 (dif.cond_ok && dif.disp_fwd)
    |-> ##2 pc == $past(pc, 2) + 12'h001 + {8'h00, $past(dif.disp_mag, 2)})
    else $error("forward short branch target wrong");
  a_short_back: assert property (s_start_short ##0 (dif.cond_ok && !dif.disp_fwd)
    |-> ##2 pc == $past(pc, 2) - {8'h00, $past(dif.disp_mag, 2)})
    else $error("backward short branch target wrong");
  a_short_flags: assert property (s_start_short |-> ##1 instr_done == 1'b0 ##1 instr_done
    && zero_flag == $past(zero_flag, 2) && carry_flag == $past(carry_flag, 2))
    else $error("short branch length or flags wrong");
  a_btest_len: assert property (s_start_bt |-> ##1 (cnt != 3'h0) [*4] ##1 cnt == 3'h0)
    else $error("bit test branch not five cycles");
  a_btest_carry: assert property (s_start_bt |-> ##5 carry_flag == $past(tested_live, 3)
    && zero_flag == $past(zero_flag, 5))
    else $error("tested bit not copied to carry");
  a_bit_write: assert property (s_start_bd |-> ##3 data_we
    && data_wdata[$past(dif.bit_idx, 3)] == $past(dif.bit_pol, 3))
    else $error("bit set or clear wrote wrong value");
  a_bdir_len: assert property (s_start_bd |-> ##3 !instr_done ##1 instr_done
    && zero_flag == $past(zero_flag, 4) && carry_flag == $past(carry_flag, 4))
    else $error("bit set or clear length or flags wrong");
  a_stop_wait: assert property (run && cnt == 3'h1 && dif.opcode == `BBCE_OP_STOP && wdg_option
    |=> wait_mode && !stop_mode)
    else $error("stop not replaced by wait");
  a_call_push: assert property (s_start_call |-> ##4 sp == $past(sp, 4) + 3'h1
    && stack[$past(sp, 4)] == $past(pc, 4) + 12'h002)
    else $error("call did not push return address");
  // An empty stack is excluded: its pop has no saved address to restore
  a_ret_pop: assert property (s_start_ret |-> ##2 pc == $past(stack[sp - 3'h1], 2)
    && sp == $past(sp, 2) - 3'h1)
    else $error("return did not restore the saved address");
  a_interrupt_exit_flags: assert property (run && cnt == 3'h1 && dif.kind == K_INTERRUPT_EXIT
    |=> zero_flag == $past(rti_zero) && carry_flag == $past(rti_carry))
    else $error("interrupt exit did not restore flags");
  a_jump_target: assert property (s_start_jump
    |-> ##4 pc == {$past(prog_data[7:4], 4), $past(prog_data, 3)})
    else $error("long jump target wrong");
endmodule

// File: verif/bbce_mem.sv
// Program memory and data space model on the far side of the core
module bbce_mem (
  // Clock
  input wire logic clk,
  // Program memory
  input wire bbce_pkg::bbce_pc_t prog_addr,
  output logic [7:0] prog_data,
  // Data space
  input wire logic [7:0] data_addr,
  output logic [7:0] data_rdata,
  input wire logic [7:0] data_wdata,
  input wire logic data_we
);
  timeunit 1ns;
  timeprecision 1ps;
  import bbce_pkg::*;
  logic [7:0] prog [4096];
  logic [7:0] data [256];

  // ****************************************
  // Storage
  // ****************************************
  // Unwritten program space holds a harmless one-byte opcode
  initial begin
    foreach (prog[i]) prog[i] = 8'h5D;
    foreach (data[i]) data[i] = 8'h00;
  end
  assign prog_data = prog[prog_addr];
  assign data_rdata = data[data_addr];
  always @(posedge clk) begin
    if (data_we) begin
      data[data_addr] <= data_wdata;
    end
  end
endmodule

// File: verif/tb_branch_bit_control_exec.sv
// Self-checking bench for the branch, bit and control execution unit
`define CHK(act, exp) begin num_checks++; if ((act) !== (exp)) begin num_errors++; \
  $display("unexpected at %0t: got %h expected %h", $time, (act), (exp)); end end
module tb_branch_bit_control_exec;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic wdg_option = 1'b0, wake = 1'b0, rti_zero = 1'b0, rti_carry = 1'b0;
  bbce_pkg::bbce_pc_t prog_addr;
  logic [7:0] prog_data, data_addr, data_rdata, data_wdata;
  logic data_we, zero_flag, carry_flag, wait_mode, stop_mode, instr_done, foreign_op;
  int num_errors = 0;
  int num_checks = 0;

  // ****************************************
  // Clock, design and memory
  // ****************************************
  always #2.5 clk = ~clk;
  bbce_core DUT (.clk(clk), .sys_rst(sys_rst), .prog_addr(prog_addr), .prog_data(prog_data),
    .data_addr(data_addr), .data_rdata(data_rdata), .data_wdata(data_wdata), .data_we(data_we),
    .wdg_option(wdg_option), .wake(wake), .rti_zero(rti_zero), .rti_carry(rti_carry),
    .zero_flag(zero_flag), .carry_flag(carry_flag), .wait_mode(wait_mode), .stop_mode(stop_mode),
    .instr_done(instr_done), .foreign_op(foreign_op));
  bbce_mem mem (.clk(clk), .prog_addr(prog_addr), .prog_data(prog_data), .data_addr(data_addr),
    .data_rdata(data_rdata), .data_wdata(data_wdata), .data_we(data_we));

  // ****************************************
  // Shared tasks
  // ****************************************
  // Program is poked while the core is held, so stray opcodes never run on new data
  task automatic hold();
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
  endtask
  // Counts cycles to the next completion and checks the next fetch address
  task automatic step(input int len, input logic [11:0] pc);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (instr_done !== 1'b1 && n < 20);
    `CHK(n, len)
    `CHK(prog_addr, pc)
  endtask
  // Both flags load together only through an interrupt exit, which needs a saved address: call one first
  task automatic start();
    mem.prog[0] = 8'hF1;
    mem.prog[1] = 8'hFF;
    mem.prog[12'hFFF] = 8'h4D;
    sys_rst <= 1'b0;
    step(4, 12'hFFF);
    step(2, 12'h002);
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  // All four conditions, both flag states, both directions at full span
  task automatic t_short();
    logic [7:0] op;
    logic [3:0] mag;
    logic f, dir, take;
    for (int k = 0; k < 8; k++) begin
      f = k[2];
      dir = k[2] ^ k[0];
      mag = k[0] ? 4'hF : 4'h7;
      op = {mag, dir, k[1:0], 1'b0};
      case (k[1:0])
        2'h0: take = !f;
        2'h1: take = !f;
        default: take = f;
      endcase
      hold();
      rti_zero <= f;
      rti_carry <= f;
      mem.prog[2] = 8'h09;
      mem.prog[3] = 8'h20;
      mem.prog[12'h020] = op;
      start();
      step(4, 12'h020);
      step(2, !take ? 12'h021 : (dir ? 12'h020 - {8'h00, mag} : 12'h021 + {8'h00, mag}));
      `CHK(zero_flag, f)
      `CHK(carry_flag, f)
    end
  endtask
  // Every bit, both polarities, both displacement extremes, both ends of data space
  task automatic t_btest();
    logic [7:0] op, dv, disp, addr;
    logic [2:0] idx;
    logic b;
    for (int k = 0; k < 16; k++) begin
      idx = k[2:0];
      dv = 8'hA5;
      b = dv[idx];
      disp = k[0] ? 8'h80 : 8'h7F;
      addr = k[1] ? 8'hFF : 8'h00;
      op = {idx[0], idx[1], idx[2], k[3], 4'h3};
      hold();
      rti_zero <= 1'b1;
      rti_carry <= ~b;
      mem.prog[2] = op;
      mem.prog[3] = addr;
      mem.prog[4] = disp;
      mem.data[addr] = dv;
      start();
      step(5, (b == k[3]) ? 12'h004 + {{4{disp[7]}}, disp} : 12'h005);
      `CHK(carry_flag, b)
      `CHK(zero_flag, 1'b1)
    end
  endtask
  task automatic t_bdir();
    logic [7:0] op, addr, m, expv;
    logic [2:0] idx;
    for (int k = 0; k < 16; k++) begin
      idx = k[2:0];
      m = 8'h01 << idx;
      addr = k[0] ? 8'hFF : 8'h00;
      expv = k[3] ? (8'h5A | m) : (8'h5A & ~m);
      op = {idx[0], idx[1], idx[2], k[3], 4'hB};
      hold();
      rti_zero <= 1'b1;
      rti_carry <= 1'b1;
      mem.prog[2] = op;
      mem.prog[3] = addr;
      mem.data[addr] = 8'h5A;
      start();
      step(4, 12'h004);
      `CHK(mem.data[addr], expv)
      `CHK(zero_flag, 1'b1)
      `CHK(carry_flag, 1'b1)
    end
  endtask
  task automatic t_jump();
    hold();
    mem.prog[0] = 8'h31;
    mem.prog[1] = 8'hA5;
    mem.prog[12'h3A5] = 8'hCD;
    mem.prog[2] = 8'h5D;
    mem.prog[3] = 8'hF9;
    mem.prog[4] = 8'hFF;
    sys_rst <= 1'b0;
    step(4, 12'h3A5);
    step(2, 12'h002);
    step(2, 12'h003);
    step(4, 12'hFFF);
    // Unhandled column is still consumed in two cycles
    hold();
    mem.prog[0] = 8'h07;
    sys_rst <= 1'b0;
    step(2, 12'h001);
    `CHK(foreign_op, 1'b1)
  endtask
  // Stop plain, stop under the watchdog option, then wait
  task automatic t_halt();
    logic [7:0] op;
    for (int k = 0; k < 3; k++) begin
      op = (k == 2) ? 8'h6D : 8'hED;
      hold();
      wdg_option <= (k == 1);
      mem.prog[0] = op;
      mem.prog[1] = 8'h5D;
      sys_rst <= 1'b0;
      step(2, 12'h001);
      repeat (3) @(posedge clk);
      #1;
      `CHK(stop_mode, k == 0)
      `CHK(wait_mode, k != 0)
      `CHK(prog_addr, 12'h001)
      @(posedge clk);
      wake <= 1'b1;
      @(posedge clk);
      wake <= 1'b0;
      step(2, 12'h002);
      `CHK(stop_mode | wait_mode, 1'b0)
    end
    wdg_option <= 1'b0;
  endtask

  // ****************************************
  // Sequence and watchdog
  // ****************************************
  initial begin
    repeat (12) @(posedge clk);
    t_short();
    t_btest();
    t_bdir();
    t_jump();
    t_halt();
    end_of_test();
  end
  // Whole run needs well under two thousand cycles
  initial begin
    #25000;
    num_errors++;
    end_of_test();
  end
endmodule
